// >>> verilog/pcf_regs.svh
`ifndef PCF_REGS_SVH
`define PCF_REGS_SVH
// Clock and line rate
`define PCF_CLK_HZ 20000000
`define PCF_BIT_KBPS 2048
// Clocks per line bit (rounded down, so the line runs slightly fast)
`define PCF_DIV ((`PCF_CLK_HZ) / (`PCF_BIT_KBPS * 1000))
// Frame geometry: 32 slots of 8 bits
`define PCF_LAST_POS 8'hFF
`define PCF_LAST_BIT 3'h7
`define PCF_SLOT_ALIGN 5'h00
`define PCF_SLOT_SIG 5'h10
// Multiframe positions
`define PCF_LAST_FRM 4'hF
`define PCF_EBIT1_FRM 4'hD
`define PCF_SMF_LAST 3'h7
// Slot 0 contents
`define PCF_FAS 7'h1B
`define PCF_MFAS 6'h0B
`define PCF_SPARE 5'h1F
// Fill octets
`define PCF_IDLE_CODE 8'hD5
`define PCF_FLAG 8'h7E
// Alignment loss after this many bad words in a row, minus one
`define PCF_MISS_LIMIT 2'h2
// Reset values
`define PCF_EBITS_RST 2'h3
`define PCF_CRC_RST 4'h0
`endif

// >>> verilog/pcf_pkg.sv
package pcf_pkg;
  // Receive alignment states
  typedef enum logic [1:0] {
    PCF_HUNT = 2'b00,
    PCF_CONF = 2'b01,
    PCF_SYNC = 2'b10
  } pcf_align_t;

  typedef logic [3:0] pcf_crc_t;

  // One bit of the x^4+x+1 remainder
  function automatic pcf_crc_t pcf_crc_step(input pcf_crc_t c, input logic d);
    logic fb;
    fb = d ^ c[3];
    return {c[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
  endfunction

  // Count of ones in an octet
  function automatic int pcf_ones(input logic [7:0] v);
    int n;
    n = 0;
    for (int i = 0; i < 8; i++) begin
      n = n + int'(v[i]);
    end
    return n;
  endfunction
endpackage

// >>> verilog/pcf_link_if.sv
`timescale 1ns/1ps
// Line between the user terminal and the network termination
interface pcf_link_if;
  logic n_bit; // Network to user data
  logic n_stb; // Network to user bit strobe
  logic u_bit; // User to network data
  logic u_stb; // User to network bit strobe
  modport user_terminal (input n_bit, input n_stb, output u_bit, output u_stb);
  modport network_termination (output n_bit, output n_stb, input u_bit, input u_stb);
endinterface

// >>> verilog/pcf_user.sv
`timescale 1ns/1ps
`include "pcf_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Framer core shared by both ends
module pcf_core #(
  parameter logic [7:0] IDLE = `PCF_IDLE_CODE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Line side
  input wire logic tx_tick,
  output logic tx_bit,
  input wire logic rx_stb,
  input wire logic rx_bit,
  // Transmit payload
  input wire logic [31:0] ts_assign,
  input wire logic [7:0] tx_octet,
  output logic [4:0] tx_slot,
  input wire logic d_valid,
  input wire logic [7:0] d_octet,
  output logic d_take,
  // Receive payload and status
  output logic [7:0] rx_octet,
  output logic [4:0] rx_slot,
  output logic rx_oct_stb,
  output logic aligned,
  output logic mf_aligned,
  output logic crc_err,
  output logic rem_err
);
  // Idle code must keep enough ones for clock recovery
  if (pcf_pkg::pcf_ones(IDLE) < 3) begin : g_idle_chk
    $error("idle code needs at least three ones");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit side
  logic [7:0] tx_pos_r; // Bit now being sent
  logic [3:0] tx_frm_r; // Frame in multiframe
  logic [6:0] tx_sh_r; // Rest of current octet
  pcf_pkg::pcf_crc_t tx_crc_r; // Running remainder
  pcf_pkg::pcf_crc_t tx_chk_r; // Remainder of last block
  logic [1:0] e_r; // Outcome of last received blocks
  logic [7:0] oct; // Octet for the slot starting now
  logic tx_now; // Bit leaving this tick
  logic tx_cbit; // Bit sits on a check position
  logic mf_bit;
  logic aligned_r;

  // Multiframe word or error indication in odd frames
  always_comb begin
    if (tx_frm_r == `PCF_EBIT1_FRM) begin
      mf_bit = e_r[0];
    end else if (tx_frm_r == `PCF_LAST_FRM) begin
      mf_bit = e_r[1];
    end else begin
      // Only the addressed bit of the word is kept
      mf_bit = 1'(`PCF_MFAS >> (3'h5 - tx_frm_r[3:1]));
    end
  end

  // Slot content selection
  always_comb begin
    if (tx_pos_r[7:3] == `PCF_SLOT_ALIGN) begin
      if (!tx_frm_r[0]) begin
        oct = {tx_chk_r[2'h3 - tx_frm_r[2:1]], `PCF_FAS};
      end else begin
        // Remote alarm raised while our receiver is out of alignment
        oct = {mf_bit, 1'b1, ~aligned_r, `PCF_SPARE};
      end
    end else if (tx_pos_r[7:3] == `PCF_SLOT_SIG) begin
      oct = d_valid ? d_octet : `PCF_FLAG;
    end else begin
      oct = ts_assign[tx_pos_r[7:3]] ? tx_octet : IDLE;
    end
  end

  assign tx_now = (tx_pos_r[2:0] == 3'h0) ? oct[7] : tx_sh_r[6];
  assign tx_cbit = (tx_pos_r[7:0] == 8'h00) && !tx_frm_r[0];

  // Bit and frame counters, 256 bits per frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_pos_r <= 8'h00;
      tx_frm_r <= 4'h0;
    end else if (clk_en && tx_tick) begin
      tx_pos_r <= tx_pos_r + 8'h01;
      if (tx_pos_r == `PCF_LAST_POS) begin
        tx_frm_r <= tx_frm_r + 4'h1;
      end
    end
  end

  // Octet serialiser, first bit of a slot first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_sh_r <= 7'h00;
      tx_bit <= 1'b1;
      tx_slot <= 5'h01;
      d_take <= 1'b0;
    end else if (clk_en) begin
      d_take <= 1'b0;
      if (tx_tick) begin
        tx_bit <= tx_now;
        tx_sh_r <= (tx_pos_r[2:0] == 3'h0) ? oct[6:0] : {tx_sh_r[5:0], 1'b0};
        if (tx_pos_r[2:0] == 3'h0) begin
          tx_slot <= tx_pos_r[7:3] + 5'h01;
          d_take <= d_valid && (tx_pos_r[7:3] == `PCF_SLOT_SIG);
        end
      end
    end
  end

  // Outgoing remainder; check positions count as zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_crc_r <= `PCF_CRC_RST;
      tx_chk_r <= `PCF_CRC_RST;
    end else if (clk_en && tx_tick) begin
      if (tx_frm_r[2:0] == `PCF_SMF_LAST && tx_pos_r == `PCF_LAST_POS) begin
        tx_chk_r <= pcf_pkg::pcf_crc_step(tx_crc_r, tx_now && !tx_cbit);
        tx_crc_r <= `PCF_CRC_RST;
      end else begin
        tx_crc_r <= pcf_pkg::pcf_crc_step(tx_crc_r, tx_now && !tx_cbit);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive side
  pcf_pkg::pcf_align_t state_r;
  logic [7:0] rx_sh_r; // Last received bits
  logic [7:0] rx_pos_r; // Position of last received bit
  logic [3:0] rx_frm_r;
  logic [1:0] miss_r; // Bad alignment words in a row
  logic [7:0] mf_sh_r; // First bits of odd frames
  pcf_pkg::pcf_crc_t rx_crc_r;
  pcf_pkg::pcf_crc_t rx_calc_r; // Remainder of previous block
  pcf_pkg::pcf_crc_t rx_c_r; // Check bits received this block
  logic calc_ok_r; // A previous remainder is held
  logic [7:0] sh_nxt;
  logic [7:0] cur_pos;
  logic [3:0] cur_frm;
  logic [7:0] mf_nxt;
  logic fas_hit, fa_chk, mf_chk, mf_hit, mf_new, smf_end;

  assign sh_nxt = {rx_sh_r[6:0], rx_bit};
  assign cur_pos = rx_pos_r + 8'h01;
  assign cur_frm = (rx_pos_r == `PCF_LAST_POS) ? rx_frm_r + 4'h1 : rx_frm_r;
  assign fas_hit = (sh_nxt[6:0] == `PCF_FAS);
  assign fa_chk = (cur_pos == 8'h07) && !cur_frm[0];
  assign mf_chk = (state_r == pcf_pkg::PCF_SYNC) && (cur_pos == 8'h00) && cur_frm[0];
  assign mf_nxt = {mf_sh_r[6:0], rx_bit};
  assign mf_hit = mf_chk && (mf_nxt[7:2] == `PCF_MFAS);
  // A match away from frame 15 means the multiframe moved
  assign mf_new = mf_hit && (!mf_aligned || cur_frm != `PCF_LAST_FRM);
  assign smf_end = (cur_frm[2:0] == `PCF_SMF_LAST) && (cur_pos == `PCF_LAST_POS);

  // Frame alignment hunt, confirm, and loss after three misses
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= pcf_pkg::PCF_HUNT;
      aligned_r <= 1'b0;
      aligned <= 1'b0;
      miss_r <= 2'h0;
    end else if (clk_en && rx_stb) begin
      case (state_r)
        pcf_pkg::PCF_HUNT: begin
          if (fas_hit) begin
            state_r <= pcf_pkg::PCF_CONF;
          end
        end
        pcf_pkg::PCF_CONF: begin
          if (fa_chk) begin
            state_r <= fas_hit ? pcf_pkg::PCF_SYNC : pcf_pkg::PCF_HUNT;
            aligned_r <= fas_hit;
            aligned <= fas_hit;
            miss_r <= 2'h0;
          end
        end
        pcf_pkg::PCF_SYNC: begin
          if (fa_chk && fas_hit) begin
            miss_r <= 2'h0;
          end else if (fa_chk && miss_r == `PCF_MISS_LIMIT) begin
            state_r <= pcf_pkg::PCF_HUNT;
            aligned_r <= 1'b0;
            aligned <= 1'b0;
          end else if (fa_chk) begin
            miss_r <= miss_r + 2'h1;
          end
        end
        default: begin
          state_r <= pcf_pkg::PCF_HUNT;
        end
      endcase
    end
  end

  // Receive counters; a hunt hit fixes the position at end of slot 0
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_sh_r <= 8'h00;
      rx_pos_r <= 8'h00;
      rx_frm_r <= 4'h0;
      mf_sh_r <= 8'h00;
      mf_aligned <= 1'b0;
    end else if (clk_en && rx_stb) begin
      rx_sh_r <= sh_nxt;
      if (state_r == pcf_pkg::PCF_HUNT && fas_hit) begin
        rx_pos_r <= 8'h07;
        rx_frm_r <= 4'h0;
      end else begin
        rx_pos_r <= cur_pos;
        rx_frm_r <= mf_new ? `PCF_LAST_FRM : cur_frm;
      end
      if (mf_chk) begin
        mf_sh_r <= mf_nxt;
      end
      if (state_r != pcf_pkg::PCF_SYNC) begin
        mf_aligned <= 1'b0;
      end else if (mf_hit) begin
        mf_aligned <= 1'b1;
      end else if (mf_chk && cur_frm == `PCF_LAST_FRM) begin
        mf_aligned <= 1'b0;
      end
    end
  end

  // Block check: remainder of each block against bits of the next
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_crc_r <= `PCF_CRC_RST;
      rx_calc_r <= `PCF_CRC_RST;
      rx_c_r <= `PCF_CRC_RST;
      calc_ok_r <= 1'b0;
      e_r <= `PCF_EBITS_RST;
      crc_err <= 1'b0;
    end else if (clk_en) begin
      crc_err <= 1'b0;
      if (rx_stb) begin
        if ((cur_pos == 8'h00) && !cur_frm[0]) begin
          rx_c_r <= {rx_c_r[2:0], rx_bit};
        end
        if (!mf_aligned || mf_new) begin
          rx_crc_r <= `PCF_CRC_RST;
          calc_ok_r <= 1'b0;
        end else if (smf_end) begin
          rx_calc_r <= pcf_pkg::pcf_crc_step(rx_crc_r, rx_bit);
          rx_crc_r <= `PCF_CRC_RST;
          // Realignment lands in frame 15, so that half is partial: wait for a whole one
          calc_ok_r <= calc_ok_r || !cur_frm[3];
          if (calc_ok_r) begin
            e_r[cur_frm[3]] <= (rx_c_r == rx_calc_r);
            crc_err <= (rx_c_r != rx_calc_r);
          end
        end else begin
          rx_crc_r <= pcf_pkg::pcf_crc_step(rx_crc_r, rx_bit && !((cur_pos == 8'h00) && !cur_frm[0]));
        end
      end
    end
  end

  // Payload octets and remote error indications; slot 0 not passed on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_octet <= 8'h00;
      rx_slot <= 5'h00;
      rx_oct_stb <= 1'b0;
      rem_err <= 1'b0;
    end else if (clk_en) begin
      rx_oct_stb <= 1'b0;
      rem_err <= 1'b0;
      if (rx_stb && aligned_r && cur_pos[2:0] == `PCF_LAST_BIT && cur_pos[7:3] != `PCF_SLOT_ALIGN) begin
        rx_octet <= sh_nxt;
        rx_slot <= cur_pos[7:3];
        rx_oct_stb <= 1'b1;
      end
      if (rx_stb && mf_aligned && !mf_new && mf_chk && !rx_bit &&
          (cur_frm == `PCF_EBIT1_FRM || cur_frm == `PCF_LAST_FRM)) begin
        rem_err <= 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// User terminal: transmit timed from the received line strobe
module pcf_user #(
  parameter logic [7:0] IDLE = `PCF_IDLE_CODE
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  // Line
  pcf_link_if.user_terminal LINK,
  // Transmit payload
  input wire logic [31:0] TS_ASSIGN,
  input wire logic [7:0] TX_OCTET,
  output logic [4:0] TX_SLOT,
  input wire logic D_VALID,
  input wire logic [7:0] D_OCTET,
  output logic D_TAKE,
  // Receive payload and status
  output logic [7:0] RX_OCTET,
  output logic [4:0] RX_SLOT,
  output logic RX_OCT_STB,
  output logic ALIGNED,
  output logic MF_ALIGNED,
  output logic CRC_ERR,
  output logic REM_ERR
);
  logic u_stb_r; // Strobe registered alongside the bit register, both one cycle after n_stb

  // Loop timing: each received bit clocks out one transmit bit
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      u_stb_r <= 1'b0;
    end else if (CLK_EN) begin
      u_stb_r <= LINK.n_stb;
    end
  end
  assign LINK.u_stb = u_stb_r;

  // Remote errors only flagged; no thresholds or counts here
  pcf_core #(.IDLE(IDLE)) u_core (
    .clk(CLK), .rst_n(RST_N), .clk_en(CLK_EN),
    .tx_tick(LINK.n_stb), .tx_bit(LINK.u_bit),
    .rx_stb(LINK.n_stb), .rx_bit(LINK.n_bit),
    .ts_assign(TS_ASSIGN), .tx_octet(TX_OCTET), .tx_slot(TX_SLOT),
    .d_valid(D_VALID), .d_octet(D_OCTET), .d_take(D_TAKE),
    .rx_octet(RX_OCTET), .rx_slot(RX_SLOT), .rx_oct_stb(RX_OCT_STB),
    .aligned(ALIGNED), .mf_aligned(MF_ALIGNED), .crc_err(CRC_ERR), .rem_err(REM_ERR)
  );
endmodule

// >>> verilog/pcf_net.sv
`timescale 1ns/1ps
`include "pcf_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Network termination: line timing master, error supervision
module pcf_net #(
  parameter logic [7:0] IDLE = `PCF_IDLE_CODE,
  parameter int DIV = `PCF_DIV,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  // Line
  pcf_link_if.network_termination LINK,
  // Transmit payload
  input wire logic [31:0] TS_ASSIGN,
  input wire logic [7:0] TX_OCTET,
  output logic [4:0] TX_SLOT,
  input wire logic D_VALID,
  input wire logic [7:0] D_OCTET,
  output logic D_TAKE,
  // Receive payload and status
  output logic [7:0] RX_OCTET,
  output logic [4:0] RX_SLOT,
  output logic RX_OCT_STB,
  output logic ALIGNED,
  output logic MF_ALIGNED,
  output logic CRC_ERR,
  output logic REM_ERR,
  // Supervision counts, saturating
  output logic [CNT_W-1:0] LOC_ERR_CNT,
  output logic [CNT_W-1:0] REM_ERR_CNT
);
  // Divider needs room for tick and serialiser
  if (DIV < 2 || DIV > 255 || CNT_W < 1) begin : g_par_chk
    $error("bad divider or counter width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit clock from the local clock
  logic [7:0] div_r;
  logic tick;
  logic n_stb_r;
  logic crc_err_w;
  logic rem_err_w;

  assign tick = (div_r == 8'(DIV - 1));

  // Free running; a stalled divider would stop the whole line
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      div_r <= 8'h00;
      n_stb_r <= 1'b0;
    end else if (CLK_EN) begin
      div_r <= tick ? 8'h00 : div_r + 8'h01;
      n_stb_r <= tick;
    end
  end
  assign LINK.n_stb = n_stb_r;

  // Same framer as the user end: frames with CRC, checks, indications
  pcf_core #(.IDLE(IDLE)) u_core (
    .clk(CLK), .rst_n(RST_N), .clk_en(CLK_EN),
    .tx_tick(tick), .tx_bit(LINK.n_bit),
    .rx_stb(LINK.u_stb), .rx_bit(LINK.u_bit),
    .ts_assign(TS_ASSIGN), .tx_octet(TX_OCTET), .tx_slot(TX_SLOT),
    .d_valid(D_VALID), .d_octet(D_OCTET), .d_take(D_TAKE),
    .rx_octet(RX_OCTET), .rx_slot(RX_SLOT), .rx_oct_stb(RX_OCT_STB),
    .aligned(ALIGNED), .mf_aligned(MF_ALIGNED), .crc_err(crc_err_w), .rem_err(rem_err_w)
  );
  assign CRC_ERR = crc_err_w;
  assign REM_ERR = rem_err_w;

  ////////////////////////////////////////////////////////////////////////////
  // Error counts for maintenance; stop at all ones
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      LOC_ERR_CNT <= '0;
      REM_ERR_CNT <= '0;
    end else if (CLK_EN) begin
      if (crc_err_w && !(&LOC_ERR_CNT)) begin
        LOC_ERR_CNT <= LOC_ERR_CNT + CNT_W'(1);
      end
      if (rem_err_w && !(&REM_ERR_CNT)) begin
        REM_ERR_CNT <= REM_ERR_CNT + CNT_W'(1);
      end
    end
  end
endmodule

// >>> tb/pcf_link_props.sv
`timescale 1ns/1ps
`include "pcf_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Line checks on both directions of the link between the two ends
module pcf_link_props #(
  parameter int DIV = 9
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Network to user
  input wire logic n_bit,
  input wire logic n_stb,
  // User to network
  input wire logic u_bit,
  input wire logic u_stb
);
  localparam logic [6:0] FAS_W = `PCF_FAS; // Alignment word, even frames
  localparam logic [5:0] MF_W = `PCF_MFAS; // Multiframe word, odd frames
  logic [7:0] n_pos_r; // Bit position in network frame
  logic [3:0] n_frm_r; // Network frame in multiframe
  logic [7:0] u_pos_r; // Bit position in user frame
  logic [3:0] u_frm_r; // User frame in multiframe

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  ////////////////////////////////////////////////////////////////////////////////
  // Network position; both ends start at frame 0 slot 0 after reset,
  // so a drift here means the sender lost count, not the receiver
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      n_pos_r <= 8'h00;
      n_frm_r <= 4'h0;
    end else if (n_stb) begin
      n_pos_r <= n_pos_r + 8'h01;
      if (n_pos_r == `PCF_LAST_POS) begin
        n_frm_r <= n_frm_r + 4'h1;
      end
    end
  end

  // User position, counted from its own strobes
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      u_pos_r <= 8'h00;
      u_frm_r <= 4'h0;
    end else if (u_stb) begin
      u_pos_r <= u_pos_r + 8'h01;
      if (u_pos_r == `PCF_LAST_POS) begin
        u_frm_r <= u_frm_r + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strobe timing
  net_stb_period_a: assert property (n_stb |-> ##DIV n_stb)
    else $error("network strobe spacing wrong");
  net_stb_single_a: assert property (n_stb |=> !n_stb)
    else $error("network strobe longer than one cycle");
  user_stb_follow_a: assert property (n_stb |=> u_stb)
    else $error("user strobe missing after network strobe");
  user_stb_cause_a: assert property (u_stb |-> $past(n_stb))
    else $error("user strobe without network strobe");
  // Bits only move with their strobe
  net_bit_hold_a: assert property (!n_stb |-> $stable(n_bit))
    else $error("network bit changed between strobes");
  user_bit_hold_a: assert property (!u_stb |-> $stable(u_bit))
    else $error("user bit changed between strobes");

  ////////////////////////////////////////////////////////////////////////////////
  // Slot 0 framing words on the wire
  net_align_word_a: assert property (n_stb && n_pos_r[7:3] == 5'h00 && n_pos_r[2:0] != 3'h0 && !n_frm_r[0]
    |-> n_bit == FAS_W[3'h7 - n_pos_r[2:0]])
    else $error("network alignment word wrong");
  user_align_word_a: assert property (u_stb && u_pos_r[7:3] == 5'h00 && u_pos_r[2:0] != 3'h0 && !u_frm_r[0]
    |-> u_bit == FAS_W[3'h7 - u_pos_r[2:0]])
    else $error("user alignment word wrong");
  net_mf_word_a: assert property (n_stb && n_pos_r == 8'h00 && n_frm_r[0] && n_frm_r < 4'hC
    |-> n_bit == MF_W[3'h5 - n_frm_r[3:1]])
    else $error("network multiframe word wrong");
  user_mf_word_a: assert property (u_stb && u_pos_r == 8'h00 && u_frm_r[0] && u_frm_r < 4'hC
    |-> u_bit == MF_W[3'h5 - u_frm_r[3:1]])
    else $error("user multiframe word wrong");
  net_odd_fixed_a: assert property (n_stb && n_pos_r == 8'h01 && n_frm_r[0] |-> n_bit)
    else $error("network odd frame fixed bit wrong");
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "pcf_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Both ends over one link; index 0 is the user end, 1 the network end
module testbench;
  localparam int DIV = 2; // Short bit period keeps multiframes cheap
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic chk_on = 1'b0; // Payload compare armed once both ends lock
  logic [31:0] ts_a [2];
  logic [7:0] tx_oct [2];
  logic [4:0] tx_slot [2];
  logic d_valid [2];
  logic [7:0] d_oct [2];
  logic d_take [2];
  logic [7:0] rx_oct [2];
  logic [4:0] rx_slot [2];
  logic rx_stb [2];
  logic aligned [2];
  logic mf_al [2];
  logic crc_err [2];
  logic rem_err [2];
  logic [15:0] loc_cnt;
  logic [15:0] rem_cnt;
  logic [7:0] tbl [2][32]; // Payload octet per slot, per end
  logic [7:0] dq [2][$]; // Signalling octets in flight, per sending end
  int crc_n [2];
  int rem_n [2];
  int err_total = 0;
  int samples_checked = 0;
  int seed_use;

  pcf_link_if pcf_link_if_inst ();

  pcf_user pcf_user_inst (
    .CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en), .LINK(pcf_link_if_inst),
    .TS_ASSIGN(ts_a[0]), .TX_OCTET(tx_oct[0]), .TX_SLOT(tx_slot[0]),
    .D_VALID(d_valid[0]), .D_OCTET(d_oct[0]), .D_TAKE(d_take[0]),
    .RX_OCTET(rx_oct[0]), .RX_SLOT(rx_slot[0]), .RX_OCT_STB(rx_stb[0]),
    .ALIGNED(aligned[0]), .MF_ALIGNED(mf_al[0]), .CRC_ERR(crc_err[0]), .REM_ERR(rem_err[0])
  );

  pcf_net #(.DIV(DIV)) pcf_net_inst (
    .CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en), .LINK(pcf_link_if_inst),
    .TS_ASSIGN(ts_a[1]), .TX_OCTET(tx_oct[1]), .TX_SLOT(tx_slot[1]),
    .D_VALID(d_valid[1]), .D_OCTET(d_oct[1]), .D_TAKE(d_take[1]),
    .RX_OCTET(rx_oct[1]), .RX_SLOT(rx_slot[1]), .RX_OCT_STB(rx_stb[1]),
    .ALIGNED(aligned[1]), .MF_ALIGNED(mf_al[1]), .CRC_ERR(crc_err[1]), .REM_ERR(rem_err[1]),
    .LOC_ERR_CNT(loc_cnt), .REM_ERR_CNT(rem_cnt)
  );

  // Wire checks sit beside the link, fed from the interface signals
  pcf_link_props #(.DIV(DIV)) pcf_link_props_inst (
    .CLK(clk), .RST_N(rst_n), .n_bit(pcf_link_if_inst.n_bit), .n_stb(pcf_link_if_inst.n_stb),
    .u_bit(pcf_link_if_inst.u_bit), .u_stb(pcf_link_if_inst.u_stb)
  );

  // 20 MHz clock
  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Bounded wait for frame and multiframe lock at both ends
  task automatic wait_lock(input int lim);
    int n;
    n = 0;
    while (!(aligned[0] === 1'b1 && aligned[1] === 1'b1 && mf_al[0] === 1'b1 && mf_al[1] === 1'b1)) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        cmp("lock", 16'h0001, 16'h0000);
        close_out();
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Drive payload from the slot tables and model each receive side
  // from what the far end was handed; queue pushes only once armed,
  // since octets sent before lock are never delivered
  always @(posedge clk) begin
    for (int e = 0; e < 2; e++) begin
      tx_oct[e] <= tbl[e][tx_slot[e]];
      // Fresh signalling octet after each take; first one loaded in reset
      if (!rst_n) begin
        d_oct[e] <= 8'($urandom);
      end else if (d_take[e] === 1'b1) begin
        if (chk_on) dq[e].push_back(d_oct[e]);
        d_oct[e] <= 8'($urandom);
      end
      if (rx_stb[e] === 1'b1 && chk_on) begin
        if (rx_slot[e] === 5'h10 && dq[1-e].size() > 0) begin
          cmp("signalling octet", {8'h00, dq[1-e].pop_front()}, {8'h00, rx_oct[e]});
        end else if (rx_slot[e] === 5'h10) begin
          cmp("signalling fill", {8'h00, `PCF_FLAG}, {8'h00, rx_oct[e]});
        end else if (ts_a[1-e][rx_slot[e]]) begin
          cmp("payload octet", {8'h00, tbl[1-e][rx_slot[e]]}, {8'h00, rx_oct[e]});
        end else begin
          cmp("idle octet", {8'h00, `PCF_IDLE_CODE}, {8'h00, rx_oct[e]});
        end
      end
      // Error pulses on a clean link
      if (rst_n && crc_err[e] === 1'b1) crc_n[e]++;
      if (rst_n && rem_err[e] === 1'b1) rem_n[e]++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: lock, traffic with signalling data, then flag fill
  initial begin
    seed_use = $urandom(32'h297A8500);
    for (int e = 0; e < 2; e++) begin
      // Payload slots idle and slot 16 on flag fill while hunting: a payload repeated every frame can mimic the alignment word
      ts_a[e] = 32'h00000000;
      d_valid[e] = 1'b0;
      for (int s = 0; s < 32; s++) tbl[e][s] = 8'($urandom);
    end
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wait_lock(40000);
    // Random slot map once locked; octets sent under the idle map drain first
    ts_a[0] <= $urandom;
    ts_a[1] <= $urandom;
    repeat (1024) @(posedge clk);
    chk_on <= 1'b1;
    d_valid[0] <= 1'b1;
    d_valid[1] <= 1'b1;
    repeat (16384) @(posedge clk);
    d_valid[0] <= 1'b0;
    d_valid[1] <= 1'b0;
    repeat (8192) @(posedge clk);
    for (int e = 0; e < 2; e++) begin
      cmp("frame lock", 16'h0001, {15'h0000, aligned[e]});
      cmp("multiframe lock", 16'h0001, {15'h0000, mf_al[e]});
      cmp("local errors", 16'h0000, crc_n[e][15:0]);
      cmp("remote errors", 16'h0000, rem_n[e][15:0]);
    end
    cmp("local count", crc_n[1][15:0], loc_cnt);
    cmp("remote count", rem_n[1][15:0], rem_cnt);
    close_out();
  end
endmodule
